// ==== cell_pkg.sv ====
// types shared by the configurable logic cells
package cell_pkg;

    // storage element mode of the sequential cell, gray along reg-latch-bypass
    typedef enum logic [1:0] {
        MODE_REG    = 2'b00,
        MODE_LATCH  = 2'b01,
        MODE_BYPASS = 2'b11
    } seq_mode_t;

    typedef logic [3:0] src_idx_t;

endpackage : cell_pkg

// ==== cell_regs.svh ====
// register offsets, field positions, reset values and routing source codes
`ifndef CELL_REGS_SVH
`define CELL_REGS_SVH

// register byte offsets on the apb bus
`define OFS_SIMPLE_SEL  12'h000
`define OFS_COMB_SEL    12'h004
`define OFS_SEQ_SEL     12'h008
`define OFS_SEQ_CTRL    12'h00c
`define OFS_DEC_SEL     12'h010
`define OFS_DEC_CTRL    12'h014
`define OFS_STATUS      12'h018

// every cell input is a 4-bit source select, field i at bit 4*i
`define SEL_W           4
`define SIMPLE_INPUTS   8
`define COMB_INPUTS     8
`define SEQ_INPUTS      8
`define DEC_INPUTS      7

// sequential cell control fields
`define SEQ_CLK_LSB     0
`define SEQ_MODE_LSB    4
`define SEQ_POL_BIT     6

// wide-decode control field
`define DEC_INV_BIT     0

// status fields
`define ST_SIMPLE_BIT   0
`define ST_COMB_BIT     1
`define ST_SEQ_BIT      2
`define ST_DEC_BIT      3
`define ST_STORE_BIT    4
`define ST_PINS_LSB     8

// reset values: all inputs tied low, storage bypassed, clock active high
`define RST_SEL         32'h0000_0000
`define RST_SEQ_CTRL    32'h0000_0070
`define RST_DEC_CTRL    32'h0000_0000

// routing source codes seen by every cell input
`define SRC_ZERO        4'h0
`define SRC_ONE         4'h1
`define SRC_FB_SIMPLE   4'h2
`define SRC_FB_COMB     4'h3
`define SRC_FB_SEQ      4'h4
`define SRC_DECODE      4'h5
`define SRC_PIN0        4'h8
`define SRC_COUNT       16
`define ROUTE_PINS      8

`endif

// ==== logic_cells.sv ====
// configurable logic cells (simple, combinatorial, sequential, wide decode) behind apb
`include "cell_regs.svh"

module logic_cells
    import cell_pkg::*;
(
    input  wire logic        SYS_CLK,
    input  wire logic        RST_N,
    input  wire logic        PSEL,
    input  wire logic        PENABLE,
    input  wire logic        PWRITE,
    input  wire logic [11:0] PADDR,
    input  wire logic [31:0] PWDATA,
    output logic      [31:0] PRDATA,
    output logic             PREADY,
    output logic             PSLVERR,
    input  wire logic [7:0]  ROUTE_IN,
    output logic             SIMPLE_OUT,
    output logic             COMB_OUT,
    output logic             SEQ_OUT,
    output logic             DECODE_OUT,
    output logic             DECODE_PAD
);

    // configuration registers
    logic [31:0] simple_sel_reg;
    logic [31:0] comb_sel_reg;
    logic [31:0] seq_sel_reg;
    logic [31:0] seq_ctrl_reg;
    logic [27:0] dec_sel_reg;
    logic        dec_inv_reg;

    // apb read path
    logic [31:0] prdata_reg;
    logic        pslverr_reg;
    logic [31:0] rdata_next;
    logic        addr_ok;

    // cell state and routing
    logic        fb_simple_reg;
    logic        fb_comb_reg;
    logic        fb_seq_reg;
    logic        fb_dec_reg;
    logic        store_reg;
    logic        clk_prev_reg;
    logic [`SRC_COUNT-1:0] src_cell;
    logic [`SRC_COUNT-1:0] src_dec;

    // picked inputs of each cell
    logic [`SIMPLE_INPUTS-1:0] s_in;
    logic [`COMB_INPUTS-1:0]   c_in;
    logic [`SEQ_INPUTS-1:0]    q_in;
    logic [`DEC_INPUTS-1:0]    w_in;
    logic                      q_clk;

    // cell internals
    logic      s_m0;
    logic      s_m1;
    logic      c_sel1;
    logic      c_sel2;
    logic      q_sel1;
    logic      q_sel2;
    logic      q_front;
    logic      q_rst;
    logic      q_level;
    logic      q_edge;
    logic      dec_and;
    logic      dec_out;
    seq_mode_t seq_mode;
    logic      seq_pol;
    logic      apb_wr;
    logic      apb_setup;

    // ---------------------------------------------------------------
    // apb slave: zero wait states, read data captured in the setup cycle
    // ---------------------------------------------------------------
    assign apb_wr    = PSEL & PENABLE & PWRITE;
    assign apb_setup = PSEL & ~PENABLE;

    // decode of the mapped offsets; anything else answers with an error
    always_comb begin
        addr_ok    = 1'b1;
        rdata_next = 32'h0000_0000;
        unique case (PADDR)
            `OFS_SIMPLE_SEL: rdata_next = simple_sel_reg;
            `OFS_COMB_SEL:   rdata_next = comb_sel_reg;
            `OFS_SEQ_SEL:    rdata_next = seq_sel_reg;
            `OFS_SEQ_CTRL:   rdata_next = {25'h000_0000, seq_ctrl_reg[6:0]};
            `OFS_DEC_SEL:    rdata_next = {4'h0, dec_sel_reg};
            `OFS_DEC_CTRL:   rdata_next = {31'h0000_0000, dec_inv_reg};
            `OFS_STATUS: begin
                rdata_next[`ST_SIMPLE_BIT]                = SIMPLE_OUT;
                rdata_next[`ST_COMB_BIT]                  = COMB_OUT;
                rdata_next[`ST_SEQ_BIT]                   = SEQ_OUT;
                rdata_next[`ST_DEC_BIT]                   = dec_out;
                rdata_next[`ST_STORE_BIT]                 = store_reg;
                rdata_next[`ST_PINS_LSB +: `ROUTE_PINS]   = ROUTE_IN;
            end
            default: begin
                addr_ok = 1'b0;
            end
        endcase
    end

    // read data and error flag settle during setup, stand through access
    always_ff @(posedge SYS_CLK or negedge RST_N) begin
        if (!RST_N) begin
            prdata_reg  <= 32'h0000_0000;
            pslverr_reg <= 1'b0;
        end else if (apb_setup) begin
            prdata_reg  <= PWRITE ? 32'h0000_0000 : rdata_next;
            pslverr_reg <= ~addr_ok;
        end
    end

    assign PRDATA  = prdata_reg;
    assign PSLVERR = pslverr_reg & PSEL & PENABLE;
    assign PREADY  = 1'b1;  // the cells never need a wait state

    // simple cell selects
    always_ff @(posedge SYS_CLK or negedge RST_N) begin
        if (!RST_N) begin
            simple_sel_reg <= `RST_SEL;
        end else if (apb_wr && PADDR == `OFS_SIMPLE_SEL) begin
            simple_sel_reg <= PWDATA;
        end
    end

    // combinatorial cell selects
    always_ff @(posedge SYS_CLK or negedge RST_N) begin
        if (!RST_N) begin
            comb_sel_reg <= `RST_SEL;
        end else if (apb_wr && PADDR == `OFS_COMB_SEL) begin
            comb_sel_reg <= PWDATA;
        end
    end

    // sequential cell selects and storage control
    always_ff @(posedge SYS_CLK or negedge RST_N) begin
        if (!RST_N) begin
            seq_sel_reg  <= `RST_SEL;
            seq_ctrl_reg <= `RST_SEQ_CTRL;
        end else if (apb_wr && PADDR == `OFS_SEQ_SEL) begin
            seq_sel_reg <= PWDATA;
        end else if (apb_wr && PADDR == `OFS_SEQ_CTRL) begin
            seq_ctrl_reg <= {25'h000_0000, PWDATA[6:0]};
        end
    end

    // wide decode selects and inversion
    always_ff @(posedge SYS_CLK or negedge RST_N) begin
        if (!RST_N) begin
            dec_sel_reg <= 28'(`RST_SEL);
            dec_inv_reg <= 1'(`RST_DEC_CTRL >> `DEC_INV_BIT);
        end else if (apb_wr && PADDR == `OFS_DEC_SEL) begin
            dec_sel_reg <= PWDATA[27:0];
        end else if (apb_wr && PADDR == `OFS_DEC_CTRL) begin
            dec_inv_reg <= PWDATA[`DEC_INV_BIT];
        end
    end

    // ---------------------------------------------------------------
    // routing: constants, feedback of cell outputs, decode output, pins
    // ---------------------------------------------------------------
    // cell outputs come back through a flop so a cell can feed itself
    // without a combinational loop; this is the path a latch uses
    always_ff @(posedge SYS_CLK or negedge RST_N) begin
        if (!RST_N) begin
            fb_simple_reg <= 1'b0;
            fb_comb_reg   <= 1'b0;
            fb_seq_reg    <= 1'b0;
            fb_dec_reg    <= 1'b0;
        end else begin
            fb_simple_reg <= SIMPLE_OUT;
            fb_comb_reg   <= COMB_OUT;
            fb_seq_reg    <= SEQ_OUT;
            fb_dec_reg    <= dec_out;
        end
    end

    // source vector for the core cells; decode output enters live
    always_comb begin
        src_cell                                 = '0;
        src_cell[`SRC_ONE]                       = 1'b1;
        src_cell[`SRC_FB_SIMPLE]                 = fb_simple_reg;
        src_cell[`SRC_FB_COMB]                   = fb_comb_reg;
        src_cell[`SRC_FB_SEQ]                    = fb_seq_reg;
        src_cell[`SRC_DECODE]                    = dec_out;
        src_cell[`SRC_PIN0 +: `ROUTE_PINS]       = ROUTE_IN;
    end

    // the decode cell sees its own output only through the flop
    always_comb begin
        src_dec              = src_cell;
        src_dec[`SRC_DECODE] = fb_dec_reg;
    end

    // crosspoints of the simple cell
    for (genvar i = 0; i < `SIMPLE_INPUTS; i++) begin : g_simple
        route_pick #(
            .SRC_W (`SRC_COUNT),
            .IDX_W (`SEL_W)
        ) u_pick (
            .src     (src_cell),
            .idx     (simple_sel_reg[i*`SEL_W +: `SEL_W]),
            .bit_out (s_in[i])
        );
    end

    // crosspoints of the combinatorial cell
    for (genvar i = 0; i < `COMB_INPUTS; i++) begin : g_comb
        route_pick #(
            .SRC_W (`SRC_COUNT),
            .IDX_W (`SEL_W)
        ) u_pick (
            .src     (src_cell),
            .idx     (comb_sel_reg[i*`SEL_W +: `SEL_W]),
            .bit_out (c_in[i])
        );
    end

    // crosspoints of the sequential cell front end
    for (genvar i = 0; i < `SEQ_INPUTS; i++) begin : g_seq
        route_pick #(
            .SRC_W (`SRC_COUNT),
            .IDX_W (`SEL_W)
        ) u_pick (
            .src     (src_cell),
            .idx     (seq_sel_reg[i*`SEL_W +: `SEL_W]),
            .bit_out (q_in[i])
        );
    end

    // crosspoint of the storage clock, any routed signal may clock it
    route_pick #(
        .SRC_W (`SRC_COUNT),
        .IDX_W (`SEL_W)
    ) u_pick_clk (
        .src     (src_cell),
        .idx     (seq_ctrl_reg[`SEQ_CLK_LSB +: `SEL_W]),
        .bit_out (q_clk)
    );

    // crosspoints of the wide decode cell
    for (genvar i = 0; i < `DEC_INPUTS; i++) begin : g_dec
        route_pick #(
            .SRC_W (`SRC_COUNT),
            .IDX_W (`SEL_W)
        ) u_pick (
            .src     (src_dec),
            .idx     (dec_sel_reg[i*`SEL_W +: `SEL_W]),
            .bit_out (w_in[i])
        );
    end

    // ---------------------------------------------------------------
    // simple cell: inputs d0 d1 d2 d3 sa sb s0 s1 (picks 0..7)
    // ---------------------------------------------------------------
    // separate first-level selects let one cell hold a latch bit
    always_comb begin
        s_m0       = s_in[4] ? s_in[1] : s_in[0];
        s_m1       = s_in[5] ? s_in[3] : s_in[2];
        SIMPLE_OUT = (s_in[6] | s_in[7]) ? s_m1 : s_m0;
    end

    // ---------------------------------------------------------------
    // combinatorial cell: inputs d0 d1 d2 d3 a0 b0 a1 b1 (picks 0..7)
    // ---------------------------------------------------------------
    // the and gate on a0/b0 costs the separate selects but buys 5-input gates
    always_comb begin
        c_sel1   = c_in[4] & c_in[5];
        c_sel2   = c_in[6] | c_in[7];
        COMB_OUT = c_sel2 ? (c_sel1 ? c_in[3] : c_in[2])
                          : (c_sel1 ? c_in[1] : c_in[0]);
    end

    // ---------------------------------------------------------------
    // sequential cell: inputs d0 d1 d2 d3 a0 b0 a1 b1 (picks 0..7)
    // b0 is the storage reset unless the storage is bypassed
    // ---------------------------------------------------------------
    assign seq_mode = (seq_ctrl_reg[`SEQ_MODE_LSB +: 2] == 2'b10)
                    ? MODE_BYPASS
                    : seq_mode_t'(seq_ctrl_reg[`SEQ_MODE_LSB +: 2]);
    assign seq_pol  = seq_ctrl_reg[`SEQ_POL_BIT];

    // front end: the select gate is dropped while b0 serves as reset
    always_comb begin
        if (seq_mode == MODE_BYPASS) begin
            q_sel1 = q_in[4] & q_in[5];
            q_rst  = 1'b0;
        end else begin
            q_sel1 = q_in[4];
            q_rst  = q_in[5];
        end
        q_sel2  = q_in[6] | q_in[7];
        q_front = q_sel2 ? (q_sel1 ? q_in[3] : q_in[2])
                         : (q_sel1 ? q_in[1] : q_in[0]);
    end

    // active level and active edge of the routed clock, per polarity
    always_comb begin
        q_level = (q_clk == seq_pol);
        q_edge  = (q_clk == seq_pol) && (clk_prev_reg != seq_pol);
    end

    // the routed clock is sampled on the system clock, so its edges are seen
    // one system cycle late and pulses shorter than a cycle are lost
    always_ff @(posedge SYS_CLK or negedge RST_N) begin
        if (!RST_N) begin
            clk_prev_reg <= 1'b0;
        end else begin
            clk_prev_reg <= q_clk;
        end
    end

    // storage element: register on the active edge, latch while level active
    always_ff @(posedge SYS_CLK or negedge RST_N) begin
        if (!RST_N) begin
            store_reg <= 1'b0;
        end else if (q_rst) begin
            store_reg <= 1'b0;
        end else begin
            unique case (seq_mode)
                MODE_REG: begin
                    if (q_edge) begin
                        store_reg <= q_front;
                    end
                end
                MODE_LATCH: begin
                    if (q_level) begin
                        store_reg <= q_front;
                    end
                end
                MODE_BYPASS: begin
                    store_reg <= 1'b0;  // unused, kept cleared
                end
            endcase
        end
    end

    // output: stored value, live data while a latch is open, or bypass
    always_comb begin
        unique case (seq_mode)
            MODE_REG:    SEQ_OUT = q_rst ? 1'b0 : store_reg;
            MODE_LATCH:  SEQ_OUT = q_rst ? 1'b0
                                 : (q_level ? q_front : store_reg);
            MODE_BYPASS: SEQ_OUT = q_front;
        endcase
    end

    // ---------------------------------------------------------------
    // wide decode cell: seven-input and, optional inversion
    // ---------------------------------------------------------------
    always_comb begin
        dec_and = &w_in;
        dec_out = dec_and ^ dec_inv_reg;
    end

    // dedicated pad path: no routing stage between the gate and the pad
    assign DECODE_PAD = dec_out;
    // copy offered to the core side for monitoring
    assign DECODE_OUT = dec_out;

endmodule : logic_cells

// ==== logic_cells_props.sv ====
// port checker for the configurable logic cell block
`include "cell_regs.svh"
module logic_cells_props (
    input wire logic        SYS_CLK,
    input wire logic        RST_N,
    input wire logic        PSEL,
    input wire logic        PENABLE,
    input wire logic        PWRITE,
    input wire logic [11:0] PADDR,
    input wire logic [31:0] PRDATA,
    input wire logic        PREADY,
    input wire logic        PSLVERR,
    input wire logic [7:0]  ROUTE_IN,
    input wire logic        SIMPLE_OUT,
    input wire logic        COMB_OUT,
    input wire logic        SEQ_OUT,
    input wire logic        DECODE_OUT,
    input wire logic        DECODE_PAD
);
    default clocking cb @(posedge SYS_CLK);
    endclocking
    default disable iff (!RST_N);

    // setup and access phases of the bus
    logic setup_c;
    logic acc_c;
    assign setup_c = PSEL && !PENABLE;
    assign acc_c   = PSEL && PENABLE;

    a_pad_copy: assert property (DECODE_PAD == DECODE_OUT)
        else $error("decode pad and core copy differ");
    a_ready_access: assert property (acc_c |-> PREADY)
        else $error("no ready in access cycle");
    a_err_access: assert property (PSLVERR |-> acc_c)
        else $error("error flag outside access cycle");
    a_err_unmapped: assert property (acc_c && PADDR > `OFS_STATUS |-> PSLVERR)
        else $error("unmapped access without error");
    a_err_mapped: assert property (acc_c && PADDR <= `OFS_STATUS && PADDR[1:0] == 2'b00
        |-> !PSLVERR)
        else $error("mapped access flagged as error");
    a_rdata_hold: assert property (!setup_c |=> $stable(PRDATA))
        else $error("read data moved outside setup");
    a_unmapped_zero: assert property (setup_c && !PWRITE && PADDR > `OFS_STATUS
        |=> PRDATA == 32'h0)
        else $error("unmapped read not zero");
    a_status_pins: assert property (setup_c && !PWRITE && PADDR == `OFS_STATUS
        |=> PRDATA[15:8] == $past(ROUTE_IN))
        else $error("status pin field wrong");
    // all selects clear in reset, so every cell sees constant low inputs
    a_reset_quiet: assert property (disable iff (1'b0) !RST_N
        |-> !(SIMPLE_OUT || COMB_OUT || SEQ_OUT || DECODE_OUT))
        else $error("cell output high during reset");

    c_err: cover property (PSLVERR);
    c_status: cover property (setup_c && PADDR == `OFS_STATUS);
    c_dec: cover property (DECODE_PAD);
    c_seq: cover property (SEQ_OUT);
endmodule : logic_cells_props

// ==== route_pick.sv ====
// one routing crosspoint: picks a single source bit for one cell input
module route_pick #(
    parameter int SRC_W = 16,
    parameter int IDX_W = 4
) (
    input  wire logic [SRC_W-1:0] src,
    input  wire logic [IDX_W-1:0] idx,
    output logic                  bit_out
);

    // a code past the source vector reads as a tied-low input
    always_comb begin
        if (32'(idx) < SRC_W) begin
            bit_out = src[idx];
        end else begin
            bit_out = 1'b0;
        end
    end

endmodule : route_pick

// ==== tb_logic_cells.sv ====
// self-checking bench for the configurable logic cells
`include "cell_regs.svh"
module tb_logic_cells import cell_pkg::*;;
    timeunit 1ns;
    timeprecision 1ns;

    logic        sys_clk = 1'b0;
    logic        rst_n   = 1'b1;
    logic        psel    = 1'b0;
    logic        penable = 1'b0;
    logic        pwrite  = 1'b0;
    logic [11:0] paddr   = 12'h000;
    logic [31:0] pwdata  = 32'h0000_0000;
    logic [7:0]  route   = 8'ha5;
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
    logic        s_out;
    logic        c_out;
    logic        q_out;
    logic        d_out;
    logic        d_pad;
    logic [31:0] s_sel, c_sel, q_sel, d_sel, q_ctrl;
    logic        d_inv, store, prev, ck;
    int          fails    = 0;
    int          n_checks = 0;

    logic_cells i_logic_cells (.SYS_CLK(sys_clk), .RST_N(rst_n), .PSEL(psel),
        .PENABLE(penable), .PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata),
        .PRDATA(prdata), .PREADY(pready), .PSLVERR(pslverr), .ROUTE_IN(route),
        .SIMPLE_OUT(s_out), .COMB_OUT(c_out), .SEQ_OUT(q_out),
        .DECODE_OUT(d_out), .DECODE_PAD(d_pad));

    always #10 sys_clk = ~sys_clk;

    // value seen by cell input i for a given select word
    function automatic logic pick(logic [31:0] s, int i, logic [7:0] r, logic d);
        logic [3:0] c;
        c = s[4*i+:4];
        if (c == `SRC_ONE) return 1'b1;
        if (c == `SRC_DECODE) return d;
        if (c >= `SRC_PIN0) return r[c[2:0]];
        return 1'b0;
    endfunction : pick

    function automatic logic dec_exp(logic [7:0] r);
        logic a;
        a = 1'b1;
        for (int i = 0; i < `DEC_INPUTS; i++) a &= pick(d_sel, i, r, 1'b0);
        return a ^ d_inv;
    endfunction : dec_exp

    function automatic logic simple_exp(logic [7:0] r);
        logic [7:0] v;
        for (int i = 0; i < 8; i++) v[i] = pick(s_sel, i, r, dec_exp(r));
        return (v[6] | v[7]) ? (v[5] ? v[3] : v[2]) : (v[4] ? v[1] : v[0]);
    endfunction : simple_exp

    // g high keeps the front gate; low frees input 5 for the storage reset
    function automatic logic front(logic [31:0] s, logic [7:0] r, logic g);
        logic [7:0] v;
        logic       s1;
        for (int i = 0; i < 8; i++) v[i] = pick(s, i, r, dec_exp(r));
        s1 = v[4] & (v[5] | !g);
        return (v[6] | v[7]) ? (s1 ? v[3] : v[2]) : (s1 ? v[1] : v[0]);
    endfunction : front

    function automatic logic seq_exp(logic [7:0] r);
        if (q_ctrl[5]) return front(q_sel, r, 1'b1);
        if (pick(q_sel, 5, r, dec_exp(r))) return 1'b0;
        if (q_ctrl[4] && pick(q_ctrl, 0, r, dec_exp(r)) == q_ctrl[6]) return front(q_sel, r, 1'b0);
        return store;
    endfunction : seq_exp

    // decode code 5 only for core cells, its own inputs see a delayed copy
    function automatic logic [31:0] rnd_sel(int n, bit dec);
        logic [31:0] s;
        int          c;
        s = 32'h0;
        for (int i = 0; i < n; i++) begin
            c = $urandom % (dec ? 11 : 10);
            s[4*i+:4] = 4'(c < 2 ? c : (c == 10 ? 5 : c + 6));
        end
        return s;
    endfunction : rnd_sel

    // storage reference; pins read here are those before this edge's update;
    // untracked while the bus reconfigures, so each round starts unknown
    always @(posedge sys_clk) begin
        ck = pick(q_ctrl, 0, route, dec_exp(route));
        if (psel || q_ctrl[5]) store = 1'bx;
        else if (pick(q_sel, 5, route, dec_exp(route))) store = 1'b0;
        else if (ck == q_ctrl[6] && (q_ctrl[4] || prev != q_ctrl[6]))
            store = front(q_sel, route, 1'b0);
        prev = psel ? 1'bx : ck;
    end

    task automatic complete_run;
        $display("checks %0d mismatches %0d", n_checks, fails);
        if (fails == 0 && n_checks > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask : complete_run

    task automatic chk(logic [31:0] got, logic [31:0] exp);
        n_checks++;
        if (got !== exp) begin
            fails++;
            $display("[ERR] %0t got %h exp %h", $time, got, exp);
        end
    endtask : chk

    // an unknown expectation means untracked storage and is skipped
    task automatic chk_bit(logic got, logic exp);
        if (exp === 1'bx) return;
        chk({31'h0, got}, {31'h0, exp});
    endtask : chk_bit

    // entered at a rising edge; leaves select up for a back-to-back setup
    task automatic apb(logic wr, logic [11:0] a, logic [31:0] wd, output logic [31:0] rd,
                       output logic er);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= wr;
        paddr   <= a;
        pwdata  <= wd;
        @(posedge sys_clk);
        penable <= 1'b1;
        for (int k = 0; k < 16; k++) begin
            @(posedge sys_clk);
            if (pready === 1'b1) break;
            if (k == 15) begin
                fails++;
                complete_run();
            end
        end
        rd = prdata;
        er = pslverr;
    endtask : apb

    task automatic wr(logic [11:0] a, logic [31:0] d);
        logic [31:0] r;
        logic        e;
        apb(1'b1, a, d, r, e);
    endtask : wr

    task automatic rdc(logic [11:0] a, logic [31:0] x, logic ex);
        logic [31:0] r;
        logic        e;
        apb(1'b0, a, 32'h0, r, e);
        chk(r, x);
        chk_bit(e, ex);
    endtask : rdc

    initial begin
        logic [31:0] v;
        logic        e;
        logic        lat;
        rst_n <= 1'b0;
        void'($urandom(32'ha64e));
        repeat (16) @(posedge sys_clk);
        rst_n <= 1'b1;
        @(posedge sys_clk);
        // reset values, reserved bits, read-only status, unmapped places
        rdc(`OFS_SEQ_CTRL, `RST_SEQ_CTRL, 1'b0);
        rdc(`OFS_DEC_SEL, `RST_SEL, 1'b0);
        wr(`OFS_SEQ_CTRL, 32'hffff_ffff);
        rdc(`OFS_SEQ_CTRL, 32'h0000_007f, 1'b0);
        wr(`OFS_STATUS, 32'hffff_ffff);
        apb(1'b0, `OFS_STATUS, 32'h0, v, e);
        chk({24'h0, v[15:8]}, 32'h0000_00a5);
        rdc(12'h01c, 32'h0, 1'b1);
        apb(1'b1, 12'h100, 32'h1234_5678, v, e);
        chk_bit(e, 1'b1);
        // random routing, constants and polarities each round, modes stepping through all four codes
        for (int n = 0; n < 24; n++) begin
            s_sel  = rnd_sel(8, 1);
            c_sel  = rnd_sel(8, 1);
            q_sel  = rnd_sel(8, 1);
            d_sel  = rnd_sel(7, 0);
            q_ctrl = {25'h0, 1'($urandom), 2'(n % 4), 4'(8 + $urandom % 8)};
            d_inv  = 1'($urandom);
            wr(`OFS_SIMPLE_SEL, s_sel);
            wr(`OFS_COMB_SEL, c_sel);
            wr(`OFS_SEQ_SEL, q_sel);
            wr(`OFS_SEQ_CTRL, q_ctrl);
            wr(`OFS_DEC_SEL, d_sel);
            wr(`OFS_DEC_CTRL, {31'h0, d_inv});
            rdc(`OFS_SEQ_SEL, q_sel, 1'b0);
            psel    <= 1'b0;
            penable <= 1'b0;
            @(negedge sys_clk);
            for (int k = 0; k < 40; k++) begin
                @(posedge sys_clk);
                route <= 8'($urandom);
                @(negedge sys_clk);
                chk_bit(d_out, dec_exp(route));
                chk_bit(d_pad, dec_exp(route));
                chk_bit(s_out, simple_exp(route));
                chk_bit(c_out, front(c_sel, route, 1'b1));
                chk_bit(q_out, seq_exp(route));
            end
            @(posedge sys_clk);
        end
        // one-cell latch: d0 is the cell's own delayed output, d1 pin 0, gate pin 1
        wr(`OFS_SIMPLE_SEL, 32'h0009_0082);
        psel    <= 1'b0;
        penable <= 1'b0;
        route   <= 8'h03;
        lat = 1'b1;
        for (int k = 0; k < 40; k++) begin
            @(negedge sys_clk);
            chk_bit(s_out, lat);
            @(posedge sys_clk);
            v[7:0] = 8'($urandom);
            route <= v[7:0];
            if (v[1]) lat = v[0];
        end
        complete_run();
    end
endmodule : tb_logic_cells

bind logic_cells logic_cells_props i_logic_cells_props (.SYS_CLK(SYS_CLK), .RST_N(RST_N),
    .PSEL(PSEL), .PENABLE(PENABLE), .PWRITE(PWRITE), .PADDR(PADDR), .PRDATA(PRDATA),
    .PREADY(PREADY), .PSLVERR(PSLVERR), .ROUTE_IN(ROUTE_IN), .SIMPLE_OUT(SIMPLE_OUT),
    .COMB_OUT(COMB_OUT), .SEQ_OUT(SEQ_OUT), .DECODE_OUT(DECODE_OUT), .DECODE_PAD(DECODE_PAD));
